// file: param_header_map.svh
// Offsets, field positions, fixed values and counts of the discovery header
`ifndef PARAM_HEADER_MAP_SVH
`define PARAM_HEADER_MAP_SVH

// Byte addresses of the two header words
`define HDR_SIG_ADDR        24'h00_0000
`define HDR_REV_ADDR        24'h00_0004
`define HDR_LAST_ADDR       24'h00_0007

// Field positions in the second word
`define HDR_MINOR_LSB       0
`define HDR_MAJOR_LSB       8
`define HDR_COUNT_LSB       16
`define HDR_PROTO_LSB       24

// Fixed header contents
`define HDR_SIGNATURE       32'h5044_4653
`define HDR_MAJOR_REV       8'h01
`define HDR_MINOR_REV       8'h08
`define HDR_COUNT_VALUE     8'h00
`define HDR_COUNT_RESERVED  8'hFF
`define HDR_COUNT_MAX       8'hFE
`define HDR_PROTO_LEGACY    8'hFF
`define HDR_PROTO_FUSED     8'hF0

// First parameter header, bytes 8 to 15
`define PH_ID_LSB           8'h00
`define PH_MINOR_REV        8'h00
`define PH_MAJOR_REV        8'h01
`define PH_LENGTH_DW        8'h01
`define PH_TABLE_PTR        24'h00_0010
`define PH_ID_MSB           8'hFF
`define UNUSED_BYTE         8'hFF

// Serial command and framing
`define CMD_READ_PARAMS     8'h5A
`define ADDR_BYTES          2'h3
`define DUMMY_BYTES         2'h1

`endif

// file: param_header_pkg.sv
// Types shared by the discovery header logic
package param_header_pkg;

   // One-hot states of the serial read sequence
   typedef enum logic [5:0] {
      ST_IDLE   = 6'b00_0001,
      ST_CMD    = 6'b00_0010,
      ST_ADDR   = 6'b00_0100,
      ST_DUMMY  = 6'b00_1000,
      ST_DATA   = 6'b01_0000,
      ST_IGNORE = 6'b10_0000
   } link_state_type;

   typedef logic [23:0] byte_addr_type;

endpackage

// file: pin_sync.sv
// Two-flop synchroniser for the serial pins and the fuse level
`timescale 1ns/1ps
module pin_sync
(
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   input  wire logic [3:0] i_async,
   output logic      [3:0] o_sync
);

   // -----------------------------------------------------
   // Synchroniser stages
   // -----------------------------------------------------
   logic [3:0] meta_reg; // First stage, read only by second

   // Reset to idle levels: select high, clock low, data and fuse high
   // Clock resets low so that no false edge follows reset
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         meta_reg <= 4'hD;
         o_sync   <= 4'hD;
      end
      else
      begin
         meta_reg <= i_async;
         o_sync   <= meta_reg;
      end
   end

endmodule

// file: param_header.sv
// Discovery header served over a single-line serial read command
`timescale 1ns/1ps
`include "param_header_map.svh"
module param_header
(
   input  wire logic i_core_clk,   // Core clock, 100 MHz
   input  wire logic i_rst,        // Asynchronous reset, active high
   input  wire logic i_cs_n,       // Serial select, active low
   input  wire logic i_sck,        // Serial clock from host
   input  wire logic i_si,         // Serial data in
   input  wire logic i_fuse_legacy,// Fuse: legacy compatible boot mode
   output logic      o_so,         // Serial data out
   output logic      o_so_oe       // High while driving serial data out
);
   import param_header_pkg::*;

   // -----------------------------------------------------
   // Pin synchronisation and edge detection
   // -----------------------------------------------------
   logic [3:0] pins_sync;          // Synchronised cs_n, sck, si, fuse
   logic       cs_n_s;             // Select after sync
   logic       sck_s;              // Clock after sync
   logic       si_s;               // Data after sync
   logic       fuse_s;             // Fuse level after sync
   logic       sck_prev_reg;       // Previous synced clock
   logic       sck_rise;           // Host clock rising edge
   logic       sck_fall;           // Host clock falling edge

   pin_sync pin_sync_inst
   (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_async    ({i_fuse_legacy, i_si, i_sck, i_cs_n}),
      .o_sync     (pins_sync)
   );

   assign cs_n_s   = pins_sync[0];
   assign sck_s    = pins_sync[1];
   assign si_s     = pins_sync[2];
   assign fuse_s   = pins_sync[3];
   assign sck_rise = ~cs_n_s & sck_s & ~sck_prev_reg;
   assign sck_fall = ~cs_n_s & ~sck_s & sck_prev_reg;

   // -----------------------------------------------------
   // Header content lookup
   // -----------------------------------------------------
   // Byte at a given address; layout is frozen, new data only in spare bytes
   function automatic logic [7:0] header_byte(input byte_addr_type addr, input logic legacy);
      logic [31:0] rev_word;
      logic [7:0]  count;
      logic [7:0]  proto;
      count = (`HDR_COUNT_VALUE == `HDR_COUNT_RESERVED) ? `HDR_COUNT_MAX : `HDR_COUNT_VALUE;
      proto = legacy ? `HDR_PROTO_LEGACY : `HDR_PROTO_FUSED;
      rev_word = ({24'h00_0000, `HDR_MINOR_REV} << `HDR_MINOR_LSB)
               | ({24'h00_0000, `HDR_MAJOR_REV} << `HDR_MAJOR_LSB)
               | ({24'h00_0000, count} << `HDR_COUNT_LSB)
               | ({24'h00_0000, proto} << `HDR_PROTO_LSB);
      // Low byte of each word sits at the lowest address
      if (addr < `HDR_REV_ADDR)
         header_byte = 8'(`HDR_SIGNATURE >> (8 * addr[1:0]));
      else if (addr <= `HDR_LAST_ADDR)
         header_byte = 8'(rev_word >> (8 * addr[1:0]));
      else if (addr == 24'h00_0008)
         header_byte = `PH_ID_LSB;
      else if (addr == 24'h00_0009)
         header_byte = `PH_MINOR_REV;
      else if (addr == 24'h00_000A)
         header_byte = `PH_MAJOR_REV;
      else if (addr == 24'h00_000B)
         header_byte = `PH_LENGTH_DW;
      else if (addr >= 24'h00_000C && addr <= 24'h00_000E)
         header_byte = 8'(`PH_TABLE_PTR >> (8 * (addr[1:0])));
      else if (addr == 24'h00_000F)
         header_byte = `PH_ID_MSB;
      else
         header_byte = `UNUSED_BYTE;
   endfunction

   // -----------------------------------------------------
   // Serial read sequence
   // -----------------------------------------------------
   link_state_type state_reg,   state_next;   // Sequence state
   logic [2:0]     bit_reg,     bit_next;     // Bit within byte
   logic [1:0]     nbyte_reg,   nbyte_next;   // Bytes in current phase
   logic [7:0]     in_reg,      in_next;      // Input shifter
   byte_addr_type  addr_reg,    addr_next;    // Read address
   logic [7:0]     out_reg,     out_next;     // Output shifter
   logic           so_reg,      so_next;      // Output bit
   logic           load;                      // Byte fetched this cycle
   logic [7:0]     fetched;                   // Byte at current address
   logic [7:0]     last_reg,    last_next;    // Last byte fetched
   logic [7:0]     shifted;                   // Input byte with new bit

   assign fetched = header_byte(addr_reg, fuse_s);
   assign shifted = {in_reg[6:0], si_s};
   assign load    = (state_reg == ST_DATA) && sck_fall && (bit_reg == 3'h0);

   // Next state and datapath
   always_comb
   begin
      state_next = state_reg;
      bit_next   = bit_reg;
      nbyte_next = nbyte_reg;
      in_next    = in_reg;
      addr_next  = addr_reg;
      out_next   = out_reg;
      so_next    = so_reg;
      last_next  = last_reg;
      if (cs_n_s)
      begin
         // Deselect ends any frame
         state_next = ST_IDLE;
         bit_next   = 3'h0;
         nbyte_next = 2'h0;
      end
      else if (state_reg == ST_DATA)
      begin
         if (sck_fall)
         begin
            // Shift out on falling edge, most significant bit first
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h0)
            begin
               so_next   = fetched[7];
               out_next  = {fetched[6:0], 1'b0};
               last_next = fetched;
               addr_next = addr_reg + 24'h00_0001;
            end
            else
            begin
               so_next  = out_reg[7];
               out_next = {out_reg[6:0], 1'b0};
            end
         end
      end
      else if (sck_rise)
      begin
         in_next  = shifted;
         bit_next = bit_reg + 3'h1;
         case (state_reg)
            ST_IDLE, ST_CMD:
            begin
               state_next = ST_CMD;
               if (bit_reg == 3'h7)
                  state_next = (shifted == `CMD_READ_PARAMS) ? ST_ADDR : ST_IGNORE;
            end
            ST_ADDR:
            begin
               if (bit_reg == 3'h7)
               begin
                  addr_next  = {addr_reg[15:0], shifted};
                  nbyte_next = nbyte_reg + 2'h1;
                  if (nbyte_reg == `ADDR_BYTES - 2'h1)
                  begin
                     state_next = ST_DUMMY;
                     nbyte_next = 2'h0;
                  end
               end
            end
            ST_DUMMY:
            begin
               if (bit_reg == 3'h7)
               begin
                  nbyte_next = nbyte_reg + 2'h1;
                  if (nbyte_reg == `DUMMY_BYTES - 2'h1)
                     state_next = ST_DATA;
               end
            end
            default:
            begin
               state_next = ST_IGNORE;
            end
         endcase
      end
   end

   // State registers
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_reg    <= ST_IDLE;
         bit_reg      <= 3'h0;
         nbyte_reg    <= 2'h0;
         in_reg       <= 8'h00;
         addr_reg     <= 24'h00_0000;
         out_reg      <= 8'h00;
         so_reg       <= 1'b0;
         last_reg     <= 8'h00;
         sck_prev_reg <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         bit_reg      <= bit_next;
         nbyte_reg    <= nbyte_next;
         in_reg       <= in_next;
         addr_reg     <= addr_next;
         out_reg      <= out_next;
         so_reg       <= so_next;
         last_reg     <= last_next;
         sck_prev_reg <= sck_s;
      end
   end

   // Output drives only during the data phase
   assign o_so    = so_reg;
   assign o_so_oe = (state_reg == ST_DATA) && ~cs_n_s;

   // -----------------------------------------------------
   // Assertions
   // -----------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   property p_sig_low;
      load && (addr_reg == `HDR_SIG_ADDR) |=> (last_reg == 8'h53) && (so_reg == 1'b0);
   endproperty
   a_sig_low: assert property (p_sig_low) else $error("Address zero did not return signature low byte");

   property p_sig_all;
      load && (addr_reg < `HDR_REV_ADDR) |=> last_reg == 8'(`HDR_SIGNATURE >> (8 * $past(addr_reg[1:0])));
   endproperty
   a_sig_all: assert property (p_sig_all) else $error("Signature byte wrong");

   property p_count;
      load && (addr_reg == 24'h00_0006) |=> last_reg == `HDR_COUNT_VALUE;
   endproperty
   a_count: assert property (p_count) else $error("Header count byte wrong");

   property p_count_reserved;
      load && (addr_reg == 24'h00_0006) |=> last_reg != `HDR_COUNT_RESERVED;
   endproperty
   a_count_reserved: assert property (p_count_reserved) else $error("Header count reads reserved code");

   property p_major;
      load && (addr_reg == 24'h00_0005) |=> last_reg == `HDR_MAJOR_REV;
   endproperty
   a_major: assert property (p_major) else $error("Major revision byte wrong");

   property p_minor;
      load && (addr_reg == 24'h00_0004) |=> (last_reg == `HDR_MINOR_REV) && (so_reg == 1'b0);
   endproperty
   a_minor: assert property (p_minor) else $error("Minor revision byte wrong or misordered");

   property p_param_rev;
      load && (addr_reg == 24'h00_0009) |=> last_reg == `PH_MINOR_REV ##0 (addr_reg == 24'h00_000A);
   endproperty
   a_param_rev: assert property (p_param_rev) else $error("Parameter header revision wrong");

   property p_proto;
      load && (addr_reg == `HDR_LAST_ADDR) |=> last_reg == ($past(fuse_s) ? `HDR_PROTO_LEGACY : `HDR_PROTO_FUSED);
   endproperty
   a_proto: assert property (p_proto) else $error("Protocol code does not follow fuse");

   property p_sequential;
      load |=> addr_reg == $past(addr_reg) + 24'h00_0001;
   endproperty
   a_sequential: assert property (p_sequential) else $error("Read address did not increment by one");

   property p_oe_data;
      cs_n_s |=> !o_so_oe;
   endproperty
   a_oe_data: assert property (p_oe_data) else $error("Output still driven after deselect");

endmodule

// file: host_model.sv
// Host controller model that issues parameter reads over the serial link
`timescale 1ns/1ps
module host_model
(
   input  wire logic i_so,      // Serial data from the device
   input  wire logic i_so_oe,   // Device drive enable
   output logic      o_cs_n,    // Select, active low
   output logic      o_sck,     // Link clock, idle low
   output logic      o_si       // Serial data to the device
);
   logic [7:0] rd_data [0:31];  // Bytes captured in the last frame
   logic       oe_any;          // Device drove at any sample
   logic       oe_all;          // Device drove at every data sample

   initial
   begin
      o_cs_n = 1'b1;
      o_sck  = 1'b0;
      o_si   = 1'b0;
   end

   // One 80 ns link clock: data set while low, device line sampled before the rise
   task automatic clock_bit(input logic b, input logic dat, output logic q);
      o_si = b;
      #40;
      q = i_so;
      oe_any = oe_any | i_so_oe;
      if (dat)
      begin
         oe_all = oe_all & (i_so_oe === 1'b1);
      end
      o_sck = 1'b1;
      #40;
      o_sck = 1'b0;
   endtask

   // Command, address MSB first, dummy byte, then n bytes; link clock still outside frames
   task automatic read_frame(input logic [7:0] cmd, input logic [23:0] addr, input int n);
      logic [39:0] hdr;
      logic        q;
      hdr    = {cmd, addr, 8'h00};
      oe_any = 1'b0;
      oe_all = 1'b1;
      #3;
      o_cs_n = 1'b0;
      #60;
      for (int i = 39; i >= 0; i--)
         clock_bit(hdr[i], 1'b0, q);
      // Reads only as many bytes as it needs, whatever the minor revision
      for (int k = 0; k < n; k++)
         for (int i = 7; i >= 0; i--)
         begin
            clock_bit(~o_si, 1'b1, q);
            rd_data[k][i] = q;
         end
      #40;
      o_cs_n = 1'b1;
      o_si   = ~o_si;
      #80;
   endtask
endmodule

// file: discoverable_param_header_tb.sv
// Self-checking bench for the discovery header served over the serial link
`timescale 1ns/1ps
`include "param_header_map.svh"
module discoverable_param_header_tb;
   logic i_core_clk;               // Core clock
   logic i_rst;                    // Reset, active high
   logic fuse_legacy;              // Boot mode fuse level
   logic cs_n;                     // Select, active low
   logic sck;                      // Link clock
   logic si;                       // Host to device data
   logic so;                       // Device to host data
   logic so_oe;                    // Device drive enable
   logic so_line;                  // Data line as the host sees it
   int   failures  = 0;            // Mismatches seen
   int   tests_run = 0;            // Comparisons made
   int   cycles    = 0;            // Clock cycles run
   localparam int CYCLE_LIMIT = 60000;

   initial
   begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   param_header param_header_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck),
      .i_si(si), .i_fuse_legacy(fuse_legacy), .o_so(so), .o_so_oe(so_oe));
   // Released line shows the inverse of the last bit, so late drive is caught
   assign so_line = so_oe ? so : ~so;
   host_model host_model_inst (.i_so(so_line), .i_so_oe(so_oe), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));

   // Reference header contents, little-endian words
   function automatic logic [7:0] exp_byte(input int a, input logic fuse);
      logic [7:0] t [0:15] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h08, 8'h01, 8'h00, 8'hFF,
                               8'h00, 8'h00, 8'h01, 8'h01, 8'h10, 8'h00, 8'h00, 8'hFF};
      if (a == 7)
         return fuse ? `HDR_PROTO_LEGACY : `HDR_PROTO_FUSED;
      if (a < 16)
         return t[a];
      return 8'hFF;
   endfunction

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_flag(input logic got, input logic exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Reset held two cycles, then synchroniser settle time
   task automatic pulse_reset();
      @(negedge i_core_clk);
      i_rst = 1'b1;
      repeat (2) @(negedge i_core_clk);
      i_rst = 1'b0;
      repeat (4) @(negedge i_core_clk);
   endtask

   // Valid read compared byte by byte against the reference
   task automatic do_read(input int addr, input int n, input logic fuse);
      @(negedge i_core_clk);
      fuse_legacy = fuse;
      repeat (4) @(negedge i_core_clk);
      host_model_inst.read_frame(8'h5A, addr[23:0], n);
      check_flag(host_model_inst.oe_all, 1'b1);
      for (int k = 0; k < n; k++)
         check_byte(host_model_inst.rd_data[k], exp_byte(addr + k, fuse));
   endtask

   // Cut a hang short
   always @(posedge i_core_clk)
   begin
      cycles++;
      if (cycles == CYCLE_LIMIT)
      begin
         failures++;
         print_verdict();
      end
   end

   initial
   begin
      logic [7:0] cmd;
      i_rst       = 1'b1;
      fuse_legacy = 1'b1;
      void'($urandom(32'he1a620cf));
      pulse_reset();
      do_read(0, 16, 1'b1);
      check_flag(host_model_inst.rd_data[6] !== 8'hFF, 1'b1);
      // Host only interprets the layout when the major revision is the known one
      check_byte(host_model_inst.rd_data[5], `HDR_MAJOR_REV);
      $display("test header done");
      do_read(4, 4, 1'b0);
      do_read(4, 4, 1'b1);
      $display("test fuse done");
      for (int r = 0; r < 4; r++)
         do_read($urandom_range(0, 31), $urandom_range(1, 24), 1'($urandom_range(0, 1)));
      $display("test random done");
      for (int r = 0; r < 3; r++)
      begin
         cmd = (r == 0) ? 8'h5B : 8'($urandom_range(0, 89));
         @(negedge i_core_clk);
         host_model_inst.read_frame(cmd, 24'h00_0000, 2);
         check_flag(host_model_inst.oe_any, 1'b0);
      end
      $display("test refused done");
      fork
         host_model_inst.read_frame(8'h5A, 24'h00_0000, 4);
         begin
            #2000;
            pulse_reset();
         end
      join
      do_read(0, 8, 1'b1);
      $display("test reset done");
      print_verdict();
   end
endmodule
